// ===== hw/dacctl_top.sv
// converter control port: reset pin, power and mute, straps, two-wire slave
`timescale 1ns/1ps
module dacctl_top #(
  parameter int REG_DEPTH = dacctl_pkg::DACCTL_REG_DEPTH
) (
  // core clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       SRST_IN,
  // master clock domain
  input  wire logic       MASTER_CLOCK_IN,
  output logic            MASTER_CLOCK_OUT,
  output logic            AUDIO_MUTE_OUT,
  // power-up reset pin and straps
  input  wire logic       POWER_UP_RESET_N_IN,
  input  wire logic       STANDALONE_STRAP_IN,
  input  wire logic       ROLE_STRAP_IN,
  input  wire logic       RATIO_STRAP_IN,
  input  wire logic       FORMAT_STRAP_IN,
  input  wire logic       TDM_VARIANT_STRAP_LOW_IN,
  input  wire logic       TDM_VARIANT_STRAP_HIGH_IN,
  input  wire logic       ADDRESS_STRAP_LOW_IN,
  input  wire logic       ADDRESS_STRAP_HIGH_IN,
  // two-wire control port
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_N_OUT,
  // status and configuration
  output logic            POWERED_OUT,
  output logic            MUTE_OUT,
  output logic            STANDALONE_OUT,
  output logic            TEMP_SENSOR_OFF_OUT,
  output logic            CLOCK_SYNTH_OFF_OUT,
  output logic            REGULATOR_OFF_OUT,
  output logic      [1:0] RATE_FAMILY_OUT,
  output logic      [9:0] CLOCK_RATIO_OUT,
  output logic            AUDIO_CLOCK_MASTER_OUT,
  output logic            TDM_MODE_OUT,
  output logic      [4:0] TDM_SLOTS_OUT,
  output logic            FRAME_HALF_DUTY_OUT
);
  import dacctl_pkg::*;

  // ----------------------------------------------------------------
  // core state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, pin_m, pin_s;
    logic [7:0] st_m, st_s;
    dacctl_i2c_state_type state;
    logic [3:0] cnt;
    logic [7:0] shift, tx, idx;
    logic rw, ack_n, drive, wr, clear, was_rst;
    logic sa_q, role_q, ratio_q, fmt_q;
    logic [1:0] tdm_q, adr_q;
    logic powered, unmute, ts_on, pll_on, vreg_on, master, tdm, half, clk_en;
    logic [1:0] fam;
    logic [9:0] ratio;
    logic [4:0] slots;
  } dacctl_core_state_type;

  typedef struct packed {
    logic en_m, en_s, mute_m, mute_s, mute_q;
  } dacctl_mclk_state_type;

  dacctl_core_state_type q;
  dacctl_core_state_type d;
  dacctl_mclk_state_type mq;
  dacctl_mclk_state_type md;
  logic [7:0] rd_data;
  logic [7:0] clk0;
  logic [7:0] pdn;
  logic [7:0] ctl0;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [6:0] my_addr;

  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  dacctl_regmem #(.DEPTH(REG_DEPTH)) u_regs (
    .clk_in      (CLK_IN),
    .srst_in     (SRST_IN),
    .clear_in    (q.clear),
    .wr_en_in    (q.wr),
    .wr_idx_in   (q.idx),
    .wr_data_in  (q.shift),
    .rd_idx_in   (q.idx),
    .rd_data_out (rd_data),
    .clk0_out    (clk0),
    .pdn_out     (pdn),
    .ctl0_out    (ctl0)
  );

  // ----------------------------------------------------------------
  // bus conditions, from synchronised copies only
  // ----------------------------------------------------------------
  assign scl_rise  = q.scl_s & ~q.scl_p;
  assign scl_fall  = ~q.scl_s & q.scl_p;
  assign bus_start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign bus_stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
  assign my_addr   = DACCTL_BASE_ADDR | {q.adr_q, 5'h00};

  always_comb begin
    logic       pwr_up;
    logic [1:0] rate_sel;
    logic [1:0] mcr;
    logic [9:0] base;
    pwr_up   = 1'b0;
    rate_sel = 2'h0;
    mcr  = 2'h0;
    base = DACCTL_RATIO_256;
    d = q;
    d.scl_m = SCL_IN;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = SDA_IN;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.pin_m = POWER_UP_RESET_N_IN;
    d.pin_s = q.pin_m;
    d.st_m  = {ADDRESS_STRAP_HIGH_IN, ADDRESS_STRAP_LOW_IN, TDM_VARIANT_STRAP_HIGH_IN,
               TDM_VARIANT_STRAP_LOW_IN, FORMAT_STRAP_IN, RATIO_STRAP_IN, ROLE_STRAP_IN,
               STANDALONE_STRAP_IN};
    d.st_s  = q.st_m;
    d.wr    = 1'b0;
    d.clear = 1'b0;

    // ---------------- two-wire slave ----------------
    if (q.sa_q) begin
      d.state = ST_IDLE;
      d.drive = 1'b0;
    end else if (bus_start) begin
      d.state = ST_ADDR;
      d.cnt   = 4'h0;
      d.drive = 1'b0;
    end else if (bus_stop) begin
      d.state = ST_IDLE;
      d.drive = 1'b0;
    end else begin
      case (q.state)
        ST_ADDR, ST_INDEX, ST_WDATA: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], q.sda_s};
            d.cnt   = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == DACCTL_BYTE_BITS) begin
            d.cnt   = 4'h0;
            d.drive = 1'b1;
            if (q.state == ST_ADDR) begin
              if (q.shift[7:1] == my_addr) begin
                d.rw    = q.shift[0];
                d.state = ST_ADDR_ACK;
              end else begin
                d.drive = 1'b0;
                d.state = ST_IDLE;
              end
            end else if (q.state == ST_INDEX) begin
              d.idx   = q.shift;
              d.state = ST_INDEX_ACK;
            end else begin
              d.wr    = 1'b1;
              d.state = ST_WDATA_ACK;
              // soft reset: clear wins over the same write
              if (q.idx == DACCTL_IDX_CLK0 && q.shift[DACCTL_CLK0_SOFT_BIT]) begin
                d.clear = 1'b1;
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            d.cnt = 4'h0;
            if (q.rw) begin
              d.tx    = rd_data;
              d.drive = ~rd_data[7];
              d.state = ST_RDATA;
            end else begin
              d.drive = 1'b0;
              d.state = ST_INDEX;
            end
          end
        end
        ST_INDEX_ACK: begin
          if (scl_fall) begin
            d.drive = 1'b0;
            d.state = ST_WDATA;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            d.drive = 1'b0;
            d.idx   = q.idx + 8'h01;
            d.state = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (q.cnt == DACCTL_BYTE_BITS) begin
              d.drive = 1'b0;
              d.idx   = q.idx + 8'h01;
              d.cnt   = 4'h0;
              d.state = ST_RACK;
            end else begin
              d.tx    = {q.tx[6:0], 1'b0};
              d.drive = ~q.tx[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            d.ack_n = q.sda_s;
          end else if (scl_fall) begin
            if (!q.ack_n) begin
              d.tx    = rd_data;
              d.drive = ~rd_data[7];
              d.state = ST_RDATA;
            end else begin
              d.state = ST_IDLE;
            end
          end
        end
        default: begin
          d.state = ST_IDLE;
          d.drive = 1'b0;
        end
      endcase
    end

    // ---------------- straps caught at release ----------------
    if (q.pin_s && q.was_rst) begin
      d.was_rst = 1'b0;
      {d.adr_q, d.tdm_q, d.fmt_q, d.ratio_q, d.role_q, d.sa_q} = q.st_s;
    end

    // ---------------- effective configuration ----------------
    pwr_up   = q.sa_q | clk0[DACCTL_CLK0_PWR_BIT];
    rate_sel = q.sa_q ? DACCTL_FAM_BASE : ctl0[DACCTL_CTL0_RATE_LSB +: 2];
    mcr = q.sa_q ? {1'b0, q.ratio_q} : clk0[DACCTL_CLK0_MCR_LSB +: 2];
    case (mcr)
      2'h0:    base = DACCTL_RATIO_256;
      2'h1:    base = DACCTL_RATIO_384;
      2'h2:    base = DACCTL_RATIO_512;
      default: base = DACCTL_RATIO_768;
    endcase
    case (rate_sel)
      2'h0:    d.fam = DACCTL_FAM_BASE;
      2'h1:    d.fam = DACCTL_FAM_DOUBLE;
      default: d.fam = DACCTL_FAM_QUAD;
    endcase
    d.ratio   = base >> d.fam;
    d.powered = q.pin_s & pwr_up;
    // standalone has no port to unmute, so it plays
    d.unmute  = d.powered & (q.sa_q | ~ctl0[DACCTL_CTL0_MUTE_BIT]);
    d.ts_on   = d.powered & (q.sa_q | ~pdn[DACCTL_PDN_TS_BIT]);
    d.pll_on  = d.powered & (q.sa_q | ~pdn[DACCTL_PDN_PLL_BIT]);
    d.vreg_on = d.powered & (q.sa_q | ~pdn[DACCTL_PDN_VREG_BIT]);
    d.master  = q.sa_q & ~q.role_q;
    d.tdm     = q.sa_q & q.fmt_q;
    d.half    = d.tdm & (q.tdm_q == 2'h3);
    case (q.tdm_q)
      DACCTL_TDM_VAR4:  d.slots = DACCTL_SLOTS_4;
      DACCTL_TDM_VAR16: d.slots = DACCTL_SLOTS_16;
      default:          d.slots = DACCTL_SLOTS_8;
    endcase
    if (!d.tdm) d.slots = DACCTL_SLOTS_2;
    d.clk_en  = q.pin_s;

    // pin low: power, clock and port off, registers back to defaults
    if (!q.pin_s) begin
      d.state   = ST_IDLE;
      d.drive   = 1'b0;
      d.clear   = 1'b1;
      d.was_rst = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // master clock domain
  // ----------------------------------------------------------------
  always_comb begin
    md        = mq;
    md.en_m   = q.clk_en;
    md.en_s   = mq.en_m;
    md.mute_m = ~q.unmute;
    md.mute_s = mq.mute_m;
    md.mute_q = mq.mute_s | ~mq.en_s;
  end

  always_ff @(posedge MASTER_CLOCK_IN) begin
    mq <= md;
  end

  // enable moves on the rising edge, so the first gated pulse may be short
  assign MASTER_CLOCK_OUT       = MASTER_CLOCK_IN & mq.en_s;
  assign AUDIO_MUTE_OUT         = mq.mute_q;
  assign SDA_OUT                = 1'b0;
  assign SDA_OE_N_OUT           = ~q.drive;
  assign POWERED_OUT            = q.powered;
  assign MUTE_OUT               = ~q.unmute;
  assign STANDALONE_OUT         = q.sa_q;
  assign TEMP_SENSOR_OFF_OUT    = ~q.ts_on;
  assign CLOCK_SYNTH_OFF_OUT    = ~q.pll_on;
  assign REGULATOR_OFF_OUT      = ~q.vreg_on;
  assign RATE_FAMILY_OUT        = q.fam;
  assign CLOCK_RATIO_OUT        = q.ratio;
  assign AUDIO_CLOCK_MASTER_OUT = q.master;
  assign TDM_MODE_OUT           = q.tdm;
  assign TDM_SLOTS_OUT          = q.slots;
  assign FRAME_HALF_DUTY_OUT    = q.half;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  a_pin_reset_off: assert property (!q.pin_s |=> !POWERED_OUT && MUTE_OUT)
    else $error("reset pin low but device active");
  a_mute_bit_holds: assert property (
    (q.pin_s && !q.sa_q && ctl0[DACCTL_CTL0_MUTE_BIT]) |=> MUTE_OUT)
    else $error("unmuted while mute bit set");
  a_idle_keeps_regs: assert property (
    (!clk0[DACCTL_CLK0_PWR_BIT] && !q.wr && !q.clear) |=> ctl0 == $past(ctl0))
    else $error("register changed while idle");
  a_sensor_off_bit: assert property (
    (q.pin_s && !q.sa_q && clk0[DACCTL_CLK0_PWR_BIT])
      |=> TEMP_SENSOR_OFF_OUT == $past(pdn[DACCTL_PDN_TS_BIT]))
    else $error("sensor shutdown does not follow its bit");
  a_soft_reset_dflt: assert property (q.clear
    |=> ctl0 == DACCTL_CTL0_RST && clk0 == DACCTL_CLK0_RST && pdn == DACCTL_PDN_RST)
    else $error("defaults not restored");
  a_rate_family: assert property ((q.pin_s && !q.sa_q) |=>
    RATE_FAMILY_OUT == ($past(ctl0[2:1]) == 2'h0 ? DACCTL_FAM_BASE :
                        $past(ctl0[2:1]) == 2'h1 ? DACCTL_FAM_DOUBLE : DACCTL_FAM_QUAD))
    else $error("rate family decode wrong");
  a_ratio_quad: assert property (
    (RATE_FAMILY_OUT == DACCTL_FAM_QUAD) |-> CLOCK_RATIO_OUT inside {10'h040, 10'h060,
                                                                      10'h080, 10'h0c0})
    else $error("quad ratio not quartered");
  a_strap_role: assert property ((q.sa_q && q.pin_s)
    |=> AUDIO_CLOCK_MASTER_OUT == !$past(q.role_q))
    else $error("role strap not honoured");
  a_strap_ratio: assert property ((q.sa_q && q.pin_s) |=>
    CLOCK_RATIO_OUT == ($past(q.ratio_q) ? DACCTL_RATIO_384 : DACCTL_RATIO_256))
    else $error("ratio strap not honoured");
  a_tdm_sixteen: assert property (
    (q.sa_q && q.fmt_q && q.tdm_q == DACCTL_TDM_VAR16) |=> TDM_SLOTS_OUT == DACCTL_SLOTS_16)
    else $error("tdm variant decode wrong");
  a_sda_when_ours: assert property (!SDA_OE_N_OUT |->
    q.state inside {ST_ADDR_ACK, ST_INDEX_ACK, ST_WDATA_ACK, ST_RDATA})
    else $error("data line driven outside ack or read");
  a_no_foreign_ack: assert property (
    (q.state == ST_ADDR && scl_fall && !bus_start && !bus_stop && q.cnt == DACCTL_BYTE_BITS
     && q.shift[7:1] != my_addr) |=> SDA_OE_N_OUT [*3])
    else $error("acknowledged a foreign address");
  a_index_advance: assert property (
    (q.state == ST_WDATA_ACK && scl_fall && !bus_start && !bus_stop && !q.sa_q && q.pin_s)
      |=> q.idx == $past(q.idx) + 8'h01)
    else $error("index did not advance");

  c_write_done: cover property (q.wr && !q.clear);
  c_read_byte: cover property (q.state == ST_RACK && scl_fall && !q.ack_n);
  c_soft_reset: cover property (q.clear && q.pin_s);
  c_standalone: cover property (STANDALONE_OUT && TDM_MODE_OUT);

endmodule : dacctl_top

// ===== hw/dacctl_pkg.sv
// shared constants, types and defaults of the converter control port
package dacctl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int         DACCTL_REG_DEPTH     = 32;
  localparam logic [6:0] DACCTL_BASE_ADDR     = 7'h04;
  localparam logic [7:0] DACCTL_IDX_CLK0      = 8'h00;
  localparam logic [7:0] DACCTL_IDX_PDN       = 8'h02;
  localparam logic [7:0] DACCTL_IDX_CTL0      = 8'h06;
  localparam int         DACCTL_CLK0_PWR_BIT  = 0;
  localparam int         DACCTL_CLK0_MCR_LSB  = 1;
  localparam int         DACCTL_CLK0_SOFT_BIT = 4;
  localparam int         DACCTL_CTL0_MUTE_BIT = 0;
  localparam int         DACCTL_CTL0_RATE_LSB = 1;
  localparam int         DACCTL_PDN_VREG_BIT  = 0;
  localparam int         DACCTL_PDN_PLL_BIT   = 1;
  localparam int         DACCTL_PDN_TS_BIT    = 2;
  localparam logic [7:0] DACCTL_CLK0_RST      = 8'h00;
  localparam logic [7:0] DACCTL_PDN_RST       = 8'h00;
  localparam logic [7:0] DACCTL_CTL0_RST      = 8'h01;
  localparam logic [7:0] DACCTL_OTHER_RST     = 8'h00;

  // ----------------------------------------------------------------
  // decoded modes
  // ----------------------------------------------------------------
  localparam logic [1:0] DACCTL_FAM_BASE      = 2'h0;
  localparam logic [1:0] DACCTL_FAM_DOUBLE    = 2'h1;
  localparam logic [1:0] DACCTL_FAM_QUAD      = 2'h2;
  localparam logic [9:0] DACCTL_RATIO_256     = 10'h100;
  localparam logic [9:0] DACCTL_RATIO_384     = 10'h180;
  localparam logic [9:0] DACCTL_RATIO_512     = 10'h200;
  localparam logic [9:0] DACCTL_RATIO_768     = 10'h300;
  localparam logic [1:0] DACCTL_TDM_VAR4      = 2'h0;
  localparam logic [1:0] DACCTL_TDM_VAR8      = 2'h1;
  localparam logic [1:0] DACCTL_TDM_VAR16     = 2'h2;
  localparam logic [4:0] DACCTL_SLOTS_2       = 5'h02;
  localparam logic [4:0] DACCTL_SLOTS_4       = 5'h04;
  localparam logic [4:0] DACCTL_SLOTS_8       = 5'h08;
  localparam logic [4:0] DACCTL_SLOTS_16      = 5'h10;
  localparam logic [3:0] DACCTL_BYTE_BITS     = 4'h8;

  // host-side settling time after the reset pin rises
  localparam int         DACCTL_STABLE_TIME_MS = 300;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INDEX, ST_INDEX_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } dacctl_i2c_state_type;

  function automatic logic [7:0] dacctl_reset_value(input int idx);
    if (idx == int'(DACCTL_IDX_CLK0)) return DACCTL_CLK0_RST;
    if (idx == int'(DACCTL_IDX_PDN)) return DACCTL_PDN_RST;
    if (idx == int'(DACCTL_IDX_CTL0)) return DACCTL_CTL0_RST;
    return DACCTL_OTHER_RST;
  endfunction : dacctl_reset_value

endpackage : dacctl_pkg

// ===== hw/dacctl_regmem.sv
// control register store with registered read data
`timescale 1ns/1ps
module dacctl_regmem #(
  parameter int DEPTH = dacctl_pkg::DACCTL_REG_DEPTH
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // return every entry to its default
  input  wire logic       clear_in,
  // write port
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_idx_in,
  input  wire logic [7:0] wr_data_in,
  // read port, data one cycle after the index
  input  wire logic [7:0] rd_idx_in,
  output logic      [7:0] rd_data_out,
  // bytes that steer the block
  output logic      [7:0] clk0_out,
  output logic      [7:0] pdn_out,
  output logic      [7:0] ctl0_out
);
  import dacctl_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            rd;
  } dacctl_mem_state_type;

  function automatic dacctl_mem_state_type init_state();
    dacctl_mem_state_type s;
    s.rd = 8'h00;
    for (int i = 0; i < DEPTH; i++) s.mem[i] = dacctl_reset_value(i);
    return s;
  endfunction : init_state

  localparam dacctl_mem_state_type MEM_RST = init_state();

  dacctl_mem_state_type q;
  dacctl_mem_state_type d;

  // clear beats a write in the same cycle
  always_comb begin
    d = q;
    for (int i = 0; i < DEPTH; i++) begin
      if (clear_in) begin
        d.mem[i] = dacctl_reset_value(i);
      end else if (wr_en_in && int'(wr_idx_in) == i) begin
        d.mem[i] = wr_data_in;
      end
    end
    d.rd = (int'(rd_idx_in) < DEPTH) ? q.mem[int'(rd_idx_in)] : 8'h00;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      q <= MEM_RST;
    end else begin
      q <= d;
    end
  end

  assign rd_data_out = q.rd;
  assign clk0_out    = q.mem[int'(DACCTL_IDX_CLK0)];
  assign pdn_out     = q.mem[int'(DACCTL_IDX_PDN)];
  assign ctl0_out    = q.mem[int'(DACCTL_IDX_CTL0)];

endmodule : dacctl_regmem

// ===== verification/dacctl_host.sv
// behavioural two-wire bus master standing in for the host controller
`timescale 1ns/1ps
module dacctl_host (
  // core clock paces the bus phases
  input  wire logic clk_in,
  // resolved data line and driven lines
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  // ------------------------------------------------------------
  // bus phases, 200 ns each, well above the slave's sync latency
  // ------------------------------------------------------------
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic hold();
    repeat (20) @(negedge clk_in);
  endtask : hold
  task automatic start();
    sda_out = 1'b1;
    hold();
    scl_out = 1'b1;
    hold();
    sda_out = 1'b0;
    hold();
    scl_out = 1'b0;
  endtask : start
  task automatic stop();
    sda_out = 1'b0;
    hold();
    scl_out = 1'b1;
    hold();
    sda_out = 1'b1;
    hold();
  endtask : stop
  task automatic bit_x(input logic b, output logic r);
    sda_out = b;
    hold();
    scl_out = 1'b1;
    hold();
    r = sda_in;
    scl_out = 1'b0;
  endtask : bit_x
  // last is the master's own ack slot: high releases it to the slave
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(last, ack);
  endtask : xfer
endmodule : dacctl_host

// ===== verification/dacctl_top_tb.sv
// self-checking bench of the converter control port
`timescale 1ns/1ps
module dacctl_top_tb;
  logic clk = 0, mclk = 0, srst = 1, pin_n = 0, sa = 0, role = 0, rat = 0, fmt = 0;
  logic tlo = 0, thi = 0, alo = 1, ahi = 1;
  logic scl, hsda, sda, oe_n, sdo, pwr, mute, amute, mco, tsd, psd, vsd, cmst, tdm, half, ack;
  logic [1:0] fam;
  logic [9:0] ratio;
  logic [4:0] slots;
  logic [7:0] rx;
  logic       sao;
  int num_errors = 0, compares = 0, cyc = 0;
  logic [9:0] rtab [4] = '{10'h100, 10'h180, 10'h200, 10'h300};
  logic [4:0] stab [4] = '{5'h04, 5'h08, 5'h10, 5'h08};
  // open-drain data line with pull-up
  assign sda = hsda & (oe_n | sdo);
  dacctl_top u_dacctl_top (.CLK_IN(clk), .SRST_IN(srst), .MASTER_CLOCK_IN(mclk),
    .MASTER_CLOCK_OUT(mco), .AUDIO_MUTE_OUT(amute), .POWER_UP_RESET_N_IN(pin_n),
    .STANDALONE_STRAP_IN(sa), .ROLE_STRAP_IN(role), .RATIO_STRAP_IN(rat),
    .FORMAT_STRAP_IN(fmt), .TDM_VARIANT_STRAP_LOW_IN(tlo), .TDM_VARIANT_STRAP_HIGH_IN(thi),
    .ADDRESS_STRAP_LOW_IN(alo), .ADDRESS_STRAP_HIGH_IN(ahi), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sdo), .SDA_OE_N_OUT(oe_n), .POWERED_OUT(pwr), .MUTE_OUT(mute),
    .STANDALONE_OUT(sao), .TEMP_SENSOR_OFF_OUT(tsd), .CLOCK_SYNTH_OFF_OUT(psd),
    .REGULATOR_OFF_OUT(vsd), .RATE_FAMILY_OUT(fam), .CLOCK_RATIO_OUT(ratio),
    .AUDIO_CLOCK_MASTER_OUT(cmst), .TDM_MODE_OUT(tdm), .TDM_SLOTS_OUT(slots),
    .FRAME_HALF_DUTY_OUT(half));
  dacctl_host u_dacctl_host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(hsda));
  initial forever #5 clk = ~clk;
  initial begin
    #3;
    forever #40 mclk = ~mclk;
  end
  // ------------------------------------------------------------
  // checking and bus tasks, straps select address 0x64
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      num_errors++;
    end
  endtask : chk
  task automatic end_of_test();
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    u_dacctl_host.start();
    u_dacctl_host.xfer(8'hc8, 1'b1, rx, ack);
    chk("addr ack", ack, 0);
    u_dacctl_host.xfer(idx, 1'b1, rx, ack);
    chk("index ack", ack, 0);
    u_dacctl_host.xfer(dat, 1'b1, rx, ack);
    chk("data echo", {ack, rx}, {1'b0, dat});
    u_dacctl_host.stop();
    repeat (4) @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e0, input logic [7:0] e1);
    u_dacctl_host.start();
    u_dacctl_host.xfer(8'hc8, 1'b1, rx, ack);
    u_dacctl_host.xfer(idx, 1'b1, rx, ack);
    u_dacctl_host.start();
    u_dacctl_host.xfer(8'hc9, 1'b1, rx, ack);
    chk("read addr ack", ack, 0);
    u_dacctl_host.xfer(8'hff, 1'b0, rx, ack);
    chk("read byte", rx, e0);
    u_dacctl_host.xfer(8'hff, 1'b1, rx, ack);
    chk("next byte", rx, e1);
    u_dacctl_host.stop();
  endtask : rd
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    srst = 0;
    repeat (8) @(negedge clk);
    chk("pin low", {pwr, mute}, 2'b01);
    pin_n = 1;
    repeat (10) @(negedge clk);
    u_dacctl_host.start();
    u_dacctl_host.xfer(8'h08, 1'b1, rx, ack);
    u_dacctl_host.stop();
    chk("foreign address", ack, 1);
    wr(8'h00, 8'h01);
    chk("powered muted", {pwr, mute}, 2'b11);
    chk("program mode", {sao, cmst, tdm, slots}, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(8'h06, 8'(i << 1));
      wr(8'h00, 8'(((3 - i) << 1) | 1));
      chk("rate family", fam, (i > 1) ? 2 : i);
      chk("clock ratio", ratio, rtab[3 - i] >> ((i > 1) ? 2 : i));
    end
    chk("unmuted", {pwr, mute, amute}, 3'b100);
    for (int k = 0; k < 3; k++) begin
      wr(8'h02, 8'(1 << k));
      chk("section off", {tsd, psd, vsd}, 1 << k);
    end
    rd(8'h01, 8'h00, 8'h04);
    wr(8'h00, 8'h00);
    chk("idle", {pwr, mute, amute}, 3'b011);
    rd(8'h05, 8'h00, 8'h06);
    wr(8'h00, 8'h11);
    rd(8'h05, 8'h00, 8'h01);
    sa = 1;
    for (int v = 0; v < 5; v++) begin
      {thi, tlo} = 2'(v);
      role = v[0];
      rat = v[1];
      fmt = (v < 4);
      pin_n = 0;
      repeat (10) @(negedge clk);
      chk("pin low", {pwr, mute, oe_n}, 3'b011);
      pin_n = 1;
      repeat (10) @(negedge clk);
      chk("standalone on", {pwr, mute, sao}, 3'b101);
      chk("role", cmst, !v[0]);
      chk("strap ratio", ratio, v[1] ? 10'h180 : 10'h100);
      chk("format", {tdm, slots}, (v < 4) ? {1'b1, stab[v % 4]} : 6'h02);
      chk("frame duty", half, v == 3);
    end
    u_dacctl_host.start();
    u_dacctl_host.xfer(8'hc8, 1'b1, rx, ack);
    u_dacctl_host.stop();
    chk("port silent", ack, 1);
    @(posedge mclk);
    #20;
    chk("clock out high", mco, 1);
    @(negedge mclk);
    #20;
    chk("clock out low", mco, 0);
    end_of_test();
  end
endmodule : dacctl_top_tb
